// File: dce_channel_ctl.sv
// Channel controller: event latching, enables, triggers, queueing, completion.
// Assumes parameter-set lookup and the transfer engine sit outside this block.
`timescale 1ns/1ps
`default_nettype none
module dce_channel_ctl
    import dce_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic [NUM_CH-1:0] PERIPH_EVENT,
    input wire logic WR_EN,
    input wire logic [3:0] WR_SEL,
    input wire logic WR_SHADOW,
    input wire logic [RG_W-1:0] WR_REGION,
    input wire logic [NUM_CH-1:0] WR_DATA,
    input wire logic RD_EN,
    input wire logic [3:0] RD_SEL,
    input wire logic RD_SHADOW,
    input wire logic [RG_W-1:0] RD_REGION,
    output logic [NUM_CH-1:0] RD_DATA,
    input wire logic CFG_WR,
    input wire logic [2:0] CFG_SEL,
    input wire logic [CH_W-1:0] CFG_INDEX,
    input wire logic [NUM_CH-1:0] CFG_DATA,
    input wire logic PARAMETER_SET_RAM_WR,
    input wire logic [PS_W-1:0] PARAMETER_SET_RAM_WR_SET,
    input wire logic [WD_W-1:0] PARAMETER_SET_RAM_WR_WORD,
    input wire logic [NUM_CH-1:0] CH_NULL,
    input wire logic [NUM_QK-1:0] QK_NULL,
    output logic TR_VALID,
    input wire logic TR_READY,
    output logic TR_QUICK,
    output logic [CH_W-1:0] TR_CHANNEL,
    output logic [PS_W-1:0] TR_PARAMETER_SET_RAM,
    output logic [EQ_W-1:0] TR_QUEUE,
    input wire logic SUB_EARLY,
    input wire logic [CH_W-1:0] SUB_CODE,
    input wire logic SUB_INT,
    input wire logic SUB_CHAIN,
    input wire logic DONE,
    input wire logic [CH_W-1:0] DONE_CODE,
    input wire logic DONE_INT,
    input wire logic DONE_CHAIN,
    input wire logic TE_BUSY,
    input wire logic [EQ_W-1:0] HIST_QUEUE,
    input wire logic [HP_W-1:0] HIST_ENTRY,
    output logic [CH_W:0] HIST_DATA,
    output logic CC_ACTIVE,
    output logic TE_ACTIVE,
    output logic CC_INT,
    output logic [NUM_RG-1:0] REGION_INT
);

    ////////////////////////////////////////////////////////////////////////////
    // Index of the lowest set bit; zero input gives zero.
    function automatic logic [CH_W-1:0] first_one(input logic [NUM_CH-1:0] v);
        logic [CH_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (v[i])
                idx = CH_W'(i);
        end
        return idx;
    endfunction : first_one

    // One-hot of a channel number.
    function automatic logic [NUM_CH-1:0] onehot(input logic [CH_W-1:0] n);
        return NUM_CH'(1) << n;
    endfunction : onehot

    ////////////////////////////////////////////////////////////////////////////
    logic [NUM_CH-1:0] event_latch, event_enable, event_set, chain_pend;
    logic [NUM_CH-1:0] interrupt_enable, interrupt_pending, sec_ev, miss_ev;
    logic [NUM_QK-1:0] quick_event_enable, quick_pend, quick_sec, quick_miss;
    logic [EQ_W-1:0] channel_queue_select [NUM_CH];
    logic [EQ_W-1:0] quick_queue_select [NUM_QK];
    logic [PS_W-1:0] quick_map_set [NUM_QK];
    logic [WD_W-1:0] quick_map_word [NUM_QK];
    logic [NUM_CH-1:0] region_channel_access_mask [NUM_RG];
    logic [NUM_QK-1:0] region_quick_access_mask [NUM_RG];
    logic [CH_W:0] hist [NUM_EQ][HIST_D];
    logic [HP_W-1:0] hist_ptr [NUM_EQ];
    dce_state_e state;

    // Write data gated by the shadow region's access mask.
    logic [NUM_CH-1:0] wmask, wd;
    logic [NUM_QK-1:0] wqd;
    assign wmask = WR_SHADOW ? region_channel_access_mask[WR_REGION] : '1;
    assign wd = WR_EN ? (WR_DATA & wmask) : '0;
    assign wqd = WR_EN ? (WR_DATA[NUM_QK-1:0] & (WR_SHADOW ?
        region_quick_access_mask[WR_REGION] : '1)) : '0;

    // Per-select write-one strobes.
    function automatic logic [NUM_CH-1:0] wsel(input dce_wsel_e s);
        return (WR_SEL == s) ? wd : '0;
    endfunction : wsel

    // Trigger candidates; quick channels rank below DMA channels.
    logic [NUM_CH-1:0] ch_cand;
    logic [NUM_QK-1:0] qk_cand;
    logic [CH_W-1:0] pick_ch;
    logic [QK_W-1:0] pick_qk;
    logic pick_is_ch, pick_any, take_sel, handoff;
    assign ch_cand = ((event_latch & event_enable) | event_set | chain_pend) & ~sec_ev;
    assign qk_cand = quick_pend & ~quick_sec;
    assign pick_ch = first_one(ch_cand);
    assign pick_qk = QK_W'(first_one(NUM_CH'(qk_cand)));
    assign pick_is_ch = |ch_cand;
    assign pick_any = pick_is_ch | (|qk_cand);
    assign take_sel = (state == S_IDLE) && pick_any;
    assign handoff = (state == S_OFFER) && TR_READY;

    // Consumed trigger bits and null-set error detection.
    logic [NUM_CH-1:0] ch_take;
    logic [NUM_QK-1:0] qk_take;
    logic sel_null;
    assign ch_take = (take_sel && pick_is_ch) ? onehot(pick_ch) : '0;
    assign qk_take = (take_sel && !pick_is_ch) ? NUM_QK'(1) << pick_qk : '0;
    assign sel_null = pick_is_ch ? CH_NULL[pick_ch] : QK_NULL[pick_qk];

    // Completion codes from early hand-off and from the engine.
    logic early;
    logic [NUM_CH-1:0] cpl_int, cpl_chain;
    assign early = handoff && SUB_EARLY;
    assign cpl_int = ((early && SUB_INT) ? onehot(SUB_CODE) : '0)
        | ((DONE && DONE_INT) ? onehot(DONE_CODE) : '0);
    assign cpl_chain = ((early && SUB_CHAIN) ? onehot(SUB_CODE) : '0)
        | ((DONE && DONE_CHAIN) ? onehot(DONE_CODE) : '0);

    // Quick trigger-word writes for enabled quick channels.
    logic [NUM_QK-1:0] qk_hit;
    always_comb
    begin
        for (int q = 0; q < NUM_QK; q++)
        begin
            qk_hit[q] = PARAMETER_SET_RAM_WR && quick_event_enable[q]
                && quick_map_set[q] == PARAMETER_SET_RAM_WR_SET
                && quick_map_word[q] == PARAMETER_SET_RAM_WR_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event latch: a high PERIPH_EVENT bit sets it, clear register or service clears it.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            event_latch <= RST_CH;
        else
            event_latch <= (event_latch & ~wsel(W_EV_CLR) & ~ch_take) | PERIPH_EVENT;
    end

    // Event enable: only the set and clear registers change it.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
            event_enable <= RST_CH;
        else
            event_enable <= (event_enable | wsel(W_EN_SET)) & ~wsel(W_EN_CLR);
    end

    // Manual and chained triggers stay pending until serviced.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            event_set <= RST_CH;
            chain_pend <= RST_CH;
        end
        else
        begin
            event_set <= (event_set & ~ch_take) | wsel(W_EV_SET);
            chain_pend <= (chain_pend & ~ch_take) | cpl_chain;
        end
    end

    // Interrupt enable and pending; completion set wins over a clear.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            interrupt_enable <= RST_CH;
            interrupt_pending <= RST_CH;
        end
        else
        begin
            interrupt_enable <= (interrupt_enable | wsel(W_IE_SET)) & ~wsel(W_IE_CLR);
            interrupt_pending <= (interrupt_pending & ~wsel(W_IP_CLR)) | cpl_int;
        end
    end

    // Null-set error bits for DMA channels.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            sec_ev <= RST_CH;
            miss_ev <= RST_CH;
        end
        else
        begin
            sec_ev <= (sec_ev & ~wsel(W_SE_CLR)) | (sel_null ? ch_take : '0);
            miss_ev <= (miss_ev & ~wsel(W_MS_CLR)) | (sel_null ? ch_take : '0);
        end
    end

    // Quick channel enable, triggers and error bits.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            quick_event_enable <= RST_QK;
            quick_pend <= RST_QK;
            quick_sec <= RST_QK;
            quick_miss <= RST_QK;
        end
        else
        begin
            quick_event_enable <= (quick_event_enable
                | (WR_SEL == W_QE_SET ? wqd : '0))
                & ~(WR_SEL == W_QE_CLR ? wqd : '0);
            quick_pend <= (quick_pend & ~qk_take) | qk_hit;
            quick_sec <= (quick_sec & ~(WR_SEL == W_QS_CLR ? wqd : '0))
                | (sel_null ? qk_take : '0);
            quick_miss <= (quick_miss & ~(WR_SEL == W_QM_CLR ? wqd : '0))
                | (sel_null ? qk_take : '0);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration: queue selects, quick maps and masks.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            for (int i = 0; i < NUM_CH; i++)
                channel_queue_select[i] <= '0;
            for (int q = 0; q < NUM_QK; q++)
            begin
                quick_queue_select[q] <= '0;
                quick_map_set[q] <= '0;
                quick_map_word[q] <= '0;
            end
            for (int r = 0; r < NUM_RG; r++)
            begin
                region_channel_access_mask[r] <= '0;
                region_quick_access_mask[r] <= '0;
            end
        end
        else if (CFG_WR)
        begin
            case (CFG_SEL)
                C_CH_Q: channel_queue_select[CFG_INDEX] <= CFG_DATA[EQ_W-1:0];
                C_QK_Q: quick_queue_select[CFG_INDEX[QK_W-1:0]] <= CFG_DATA[EQ_W-1:0];
                C_QMAP:
                begin
                    quick_map_set[CFG_INDEX[QK_W-1:0]] <=
                        CFG_DATA[QMAP_PS_LSB +: PS_W];
                    quick_map_word[CFG_INDEX[QK_W-1:0]] <=
                        CFG_DATA[QMAP_WD_LSB +: WD_W];
                end
                C_RMASK: region_channel_access_mask[CFG_INDEX[RG_W-1:0]] <= CFG_DATA;
                C_RQMASK: region_quick_access_mask[CFG_INDEX[RG_W-1:0]] <=
                    CFG_DATA[NUM_QK-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submission: select a trigger, offer it until the engine takes it.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            state <= S_IDLE;
            TR_QUICK <= 1'b0;
            TR_CHANNEL <= '0;
            TR_PARAMETER_SET_RAM <= '0;
            TR_QUEUE <= '0;
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    if (take_sel && !sel_null)
                    begin
                        state <= S_OFFER;
                        TR_QUICK <= !pick_is_ch;
                        TR_CHANNEL <= pick_is_ch ? pick_ch : CH_W'(pick_qk);
                        TR_PARAMETER_SET_RAM <= pick_is_ch ? PS_W'(pick_ch) : quick_map_set[pick_qk];
                        TR_QUEUE <= pick_is_ch ? channel_queue_select[pick_ch]
                            : quick_queue_select[pick_qk];
                    end
                end
                S_OFFER:
                begin
                    if (TR_READY)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    assign TR_VALID = (state == S_OFFER);

    // Event queue history: last entries per queue, oldest overwritten.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            for (int e = 0; e < NUM_EQ; e++)
            begin
                hist_ptr[e] <= '0;
                for (int k = 0; k < HIST_D; k++)
                    hist[e][k] <= '0;
            end
        end
        else if (handoff)
        begin
            hist[TR_QUEUE][hist_ptr[TR_QUEUE]] <= {TR_QUICK, TR_CHANNEL};
            hist_ptr[TR_QUEUE] <= hist_ptr[TR_QUEUE] + HP_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; a shadow view masks channel registers to the region's channel bits, quick registers to its quick bits; R_ST is unmasked.
    logic [NUM_CH-1:0] rmask, rqmask, rv;
    assign rmask = RD_SHADOW ? region_channel_access_mask[RD_REGION] : '1;
    assign rqmask = RD_SHADOW ? {{(NUM_CH-NUM_QK){1'b0}},
        region_quick_access_mask[RD_REGION]} : '1;
    always_comb
    begin
        case (RD_SEL)
            R_EV: rv = event_latch & rmask;
            R_EN: rv = event_enable & rmask;
            R_IE: rv = interrupt_enable & rmask;
            R_IP: rv = interrupt_pending & rmask;
            R_SE: rv = sec_ev & rmask;
            R_MS: rv = miss_ev & rmask;
            R_QE: rv = NUM_CH'(quick_event_enable) & rqmask;
            R_QS: rv = NUM_CH'(quick_sec) & rqmask;
            R_QM: rv = NUM_CH'(quick_miss) & rqmask;
            R_ST: rv = NUM_CH'({TE_BUSY, CC_ACTIVE});
            default: rv = '0;
        endcase
    end

    // Read and history data are registered.
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            RD_DATA <= '0;
            HIST_DATA <= '0;
        end
        else
        begin
            if (RD_EN)
                RD_DATA <= rv;
            HIST_DATA <= hist[HIST_QUEUE][HIST_ENTRY];
        end
    end

    // Activity status and completion interrupts.
    logic [NUM_CH-1:0] ip_live;
    assign ip_live = interrupt_pending & interrupt_enable;
    always_ff @(posedge SYS_CLK)
    begin
        if (RESET)
        begin
            CC_ACTIVE <= 1'b0;
            TE_ACTIVE <= 1'b0;
            CC_INT <= 1'b0;
            REGION_INT <= '0;
        end
        else
        begin
            CC_ACTIVE <= pick_any || (state == S_OFFER);
            TE_ACTIVE <= TE_BUSY;
            CC_INT <= |ip_live;
            for (int r = 0; r < NUM_RG; r++)
                REGION_INT[r] <= |(ip_live & region_channel_access_mask[r]);
        end
    end

endmodule : dce_channel_ctl
`default_nettype wire

// File: dce_pkg.sv
// Package for the DMA channel controller: widths and selectors.
// Assumes a single clock domain and plain strobe ports, with no register bus.
package dce_pkg;
    localparam int NUM_CH = 32;
    localparam int NUM_QK = 8;
    localparam int NUM_RG = 4;
    localparam int NUM_EQ = 4;
    localparam int HIST_D = 4;
    localparam int CH_W = 5;
    localparam int QK_W = 3;
    localparam int RG_W = 2;
    localparam int EQ_W = 2;
    localparam int PS_W = 7;
    localparam int WD_W = 3;
    localparam int HP_W = 2;
    // Quick channel map layout in CFG_DATA.
    localparam int QMAP_PS_LSB = 0;
    localparam int QMAP_WD_LSB = 7;
    // Reset values.
    localparam logic [NUM_CH-1:0] RST_CH = 32'h0000_0000;
    localparam logic [NUM_QK-1:0] RST_QK = 8'h00;
    // Bit-register write selectors.
    typedef enum logic [3:0] {
        W_EV_CLR = 4'h0, W_EV_SET = 4'h1, W_EN_SET = 4'h2, W_EN_CLR = 4'h3,
        W_IE_SET = 4'h4, W_IE_CLR = 4'h5, W_IP_CLR = 4'h6, W_SE_CLR = 4'h7,
        W_MS_CLR = 4'h8, W_QE_SET = 4'h9, W_QE_CLR = 4'ha, W_QS_CLR = 4'hb,
        W_QM_CLR = 4'hc
    } dce_wsel_e;
    // Read selectors.
    typedef enum logic [3:0] {
        R_EV = 4'h0, R_EN = 4'h1, R_IE = 4'h2, R_IP = 4'h3, R_SE = 4'h4,
        R_MS = 4'h5, R_QE = 4'h6, R_QS = 4'h7, R_QM = 4'h8, R_ST = 4'h9
    } dce_rsel_e;
    // Configuration write selectors.
    typedef enum logic [2:0] {
        C_CH_Q = 3'h0, C_QK_Q = 3'h1, C_QMAP = 3'h2, C_RMASK = 3'h3,
        C_RQMASK = 3'h4
    } dce_csel_e;
    // Submission state: idle or offering a request.
    typedef enum logic {
        S_IDLE = 1'b0,
        S_OFFER = 1'b1
    } dce_state_e;
endpackage : dce_pkg

// File: dce_channel_ctl_sva.sv
// Checker for the channel controller: handshake and interrupts.
// Bound to every dce_channel_ctl instance; it sees that module's ports only.
`timescale 1ns/1ps
`default_nettype none
module dce_channel_ctl_sva
    import dce_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic WR_EN,
    input wire logic [3:0] WR_SEL,
    input wire logic WR_SHADOW,
    input wire logic [NUM_CH-1:0] WR_DATA,
    input wire logic [NUM_CH-1:0] CH_NULL,
    input wire logic TR_VALID,
    input wire logic TR_READY,
    input wire logic TR_QUICK,
    input wire logic [CH_W-1:0] TR_CHANNEL,
    input wire logic [PS_W-1:0] TR_PARAMETER_SET_RAM,
    input wire logic [EQ_W-1:0] TR_QUEUE,
    input wire logic DONE,
    input wire logic TE_BUSY,
    input wire logic TE_ACTIVE,
    input wire logic CC_INT,
    input wire logic [NUM_RG-1:0] REGION_INT
);
    logic hs;
    // High at the edge at which a request is handed over.
    assign hs = TR_VALID && TR_READY;
    default clocking dc @(posedge SYS_CLK);
    endclocking
    default disable iff (RESET);
    ////////////////////////////////////////////////////////////////////////////////
    // Handshake, trigger, interrupt and engine status relations.
    a_tr_hold: assert property (TR_VALID && !TR_READY |=> TR_VALID && $stable(TR_CHANNEL)
        && $stable(TR_PARAMETER_SET_RAM) && $stable(TR_QUEUE) && $stable(TR_QUICK))
        else $error("request moved while stalled");
    a_tr_drop: assert property (hs |=> !TR_VALID)
        else $error("request held after hand-off");
    a_tr_parameter_set_ram: assert property (TR_VALID && !TR_QUICK |-> TR_PARAMETER_SET_RAM == {2'h0, TR_CHANNEL})
        else $error("parameter set differs from channel");
    a_null_skip: assert property ($rose(TR_VALID) && !TR_QUICK |-> !CH_NULL[TR_CHANNEL])
        else $error("request offered for a null set");
    a_manual_go: assert property (WR_EN && !WR_SHADOW && WR_SEL == W_EV_SET && WR_DATA != '0
        && CH_NULL == '0 && !TR_VALID |-> ##[1:40] TR_VALID)
        else $error("manual trigger not offered");
    a_region_int: assert property (REGION_INT != '0 |-> CC_INT)
        else $error("region interrupt without controller interrupt");
    a_pend_clear: assert property ((WR_EN && !WR_SHADOW && WR_SEL == W_IP_CLR && WR_DATA == '1
        && !DONE && !hs) ##1 (!DONE && !hs) |=> !CC_INT && REGION_INT == '0)
        else $error("interrupt stays after pending clear");
    a_te_status: assert property (TE_BUSY |=> TE_ACTIVE)
        else $error("engine activity not shown");
endmodule : dce_channel_ctl_sva
////////////////////////////////////////////////////////////////////////////////
bind dce_channel_ctl dce_channel_ctl_sva u_sva (.SYS_CLK, .RESET, .WR_EN, .WR_SEL, .WR_SHADOW,
    .WR_DATA, .CH_NULL, .TR_VALID, .TR_READY, .TR_QUICK, .TR_CHANNEL, .TR_PARAMETER_SET_RAM, .TR_QUEUE,
    .DONE, .TE_BUSY, .TE_ACTIVE, .CC_INT, .REGION_INT);
`default_nettype wire

// File: dce_te_model.sv
// Transfer engine model: accepts requests after a stall and reports completion.
// Assumes stall, early, chain and code change only while no request is open.
`timescale 1ns/1ps
`default_nettype none
module dce_te_model
    import dce_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic tr_valid,
    input wire logic [CH_W-1:0] tr_channel,
    input wire logic [3:0] stall,
    input wire logic early,
    input wire logic chain,
    input wire logic [CH_W-1:0] code,
    output logic tr_ready,
    output logic sub_early,
    output logic [CH_W-1:0] sub_code,
    output logic sub_int,
    output logic sub_chain,
    output logic done,
    output logic [CH_W-1:0] done_code,
    output logic done_int,
    output logic done_chain,
    output logic te_busy
);
    logic [3:0] cnt;
    logic [1:0] dly;
    logic [CH_W-1:0] ch;
    // Accepts an offered request after the stall count.
    always_ff @(posedge clk)
    begin
        if (rst || !tr_valid || tr_ready)
        begin
            tr_ready <= 1'b0;
            cnt <= 4'h0;
        end
        else if (cnt == stall)
            tr_ready <= 1'b1;
        else
            cnt <= cnt + 4'h1;
    end
    // Runs a short transfer after a normal hand-off.
    always_ff @(posedge clk)
    begin
        if (rst)
            dly <= 2'h0;
        else if (tr_valid && tr_ready && !early)
        begin
            dly <= 2'h3;
            ch <= tr_channel;
        end
        else if (dly != 2'h0)
            dly <= dly - 2'h1;
    end
    // Options and completion; the code and early lines not in use show inverted values.
    assign done = dly == 2'h1;
    assign te_busy = dly != 2'h0;
    assign done_int = done;
    assign done_code = done ? code : ~code;
    assign done_chain = done && chain && code != ch;
    assign sub_early = tr_valid ? early : ~early;
    assign sub_code = tr_valid ? code : ~code;
    assign sub_int = tr_valid;
    assign sub_chain = tr_valid && chain && code != tr_channel;
endmodule : dce_te_model
`default_nettype wire

// File: dce_channel_ctl_tb.sv
// Testbench for the channel controller's strobe ports.
// Assumes the package, engine model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module dce_channel_ctl_tb import dce_pkg::*;;
    logic SYS_CLK, RESET, WR_EN, WR_SHADOW, RD_EN, RD_SHADOW, CFG_WR, PARAMETER_SET_RAM_WR, TR_VALID;
    logic TR_READY, TR_QUICK, SUB_EARLY, SUB_INT, SUB_CHAIN, DONE, DONE_INT, DONE_CHAIN;
    logic TE_BUSY, CC_ACTIVE, TE_ACTIVE, CC_INT, early, chain, found;
    logic [3:0] WR_SEL, RD_SEL, REGION_INT, stall;
    logic [2:0] CFG_SEL, PARAMETER_SET_RAM_WR_WORD;
    logic [1:0] WR_REGION, RD_REGION, TR_QUEUE, HIST_QUEUE, HIST_ENTRY;
    logic [4:0] CFG_INDEX, TR_CHANNEL, SUB_CODE, DONE_CODE, code;
    logic [31:0] PERIPH_EVENT, WR_DATA, RD_DATA, CFG_DATA, CH_NULL;
    logic [6:0] PARAMETER_SET_RAM_WR_SET, TR_PARAMETER_SET_RAM;
    logic [5:0] HIST_DATA;
    logic [7:0] QK_NULL;
    int errors, total_checks;
    dce_channel_ctl uut (.*);
    dce_te_model te (.clk(SYS_CLK), .rst(RESET), .tr_valid(TR_VALID), .tr_channel(TR_CHANNEL),
        .stall(stall), .early(early), .chain(chain), .code(code), .tr_ready(TR_READY),
        .sub_early(SUB_EARLY), .sub_code(SUB_CODE), .sub_int(SUB_INT), .sub_chain(SUB_CHAIN),
        .done(DONE), .done_code(DONE_CODE), .done_int(DONE_INT), .done_chain(DONE_CHAIN),
        .te_busy(TE_BUSY));
    // Makes the 50 MHz clock.
    initial
    begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Compares one result and counts it.
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Bit register write, one strobe cycle.
    task automatic wr(input dce_wsel_e s, input logic [31:0] d, input logic sh = 1'b0,
        input logic [1:0] rg = 2'h0);
        @(posedge SYS_CLK);
        WR_EN <= 1'b1;
        WR_SEL <= s;
        WR_DATA <= d;
        WR_SHADOW <= sh;
        WR_REGION <= rg;
        @(posedge SYS_CLK);
        WR_EN <= 1'b0;
    endtask : wr
    // Read strobe, then compare the registered data.
    task automatic rd(input dce_rsel_e s, input logic [31:0] exp, input string nm,
        input logic sh = 1'b0, input logic [1:0] rg = 2'h0);
        @(posedge SYS_CLK);
        RD_EN <= 1'b1;
        RD_SEL <= s;
        RD_SHADOW <= sh;
        RD_REGION <= rg;
        @(posedge SYS_CLK);
        RD_EN <= 1'b0;
        @(negedge SYS_CLK);
        chk(nm, exp, RD_DATA);
    endtask : rd
    // Configuration write, one strobe cycle.
    task automatic cfg(input dce_csel_e s, input logic [4:0] idx, input logic [31:0] d);
        @(posedge SYS_CLK);
        CFG_WR <= 1'b1;
        CFG_SEL <= s;
        CFG_INDEX <= idx;
        CFG_DATA <= d;
        @(posedge SYS_CLK);
        CFG_WR <= 1'b0;
    endtask : cfg
    // Parameter write or peripheral event pulse.
    task automatic pwr(input logic [6:0] st, input logic [2:0] wd);
        @(posedge SYS_CLK);
        PARAMETER_SET_RAM_WR <= 1'b1;
        PARAMETER_SET_RAM_WR_SET <= st;
        PARAMETER_SET_RAM_WR_WORD <= wd;
        @(posedge SYS_CLK);
        PARAMETER_SET_RAM_WR <= 1'b0;
    endtask : pwr
    task automatic pev(input logic [31:0] ev);
        @(posedge SYS_CLK);
        PERIPH_EVENT <= ev;
        @(posedge SYS_CLK);
        PERIPH_EVENT <= 32'h0;
    endtask : pev
    // Waits out an open request, then for the next offer.
    task automatic wait_tr();
        int n;
        n = 0;
        do
        begin
            @(negedge SYS_CLK);
            n++;
        end
        while (TR_VALID === 1'b1 && n < 60);
        while (TR_VALID !== 1'b1 && n < 60)
        begin
            @(negedge SYS_CLK);
            n++;
        end
        chk("offer", 32'h1, {31'h0, TR_VALID});
    endtask : wait_tr
    task automatic idle(input int n);
        repeat (n) @(negedge SYS_CLK);
    endtask : idle
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog; the tests need about one hundred and seventy-five cycles.
    initial
    begin
        repeat (20000) @(posedge SYS_CLK);
        errors++;
        print_verdict();
    end
    // Main test sequence.
    initial
    begin
        RESET = 1'b1;
        {WR_EN, RD_EN, CFG_WR, PARAMETER_SET_RAM_WR, WR_SHADOW, RD_SHADOW, early, chain} = '0;
        {WR_SEL, RD_SEL, WR_REGION, RD_REGION, CFG_SEL, CFG_INDEX, stall, code} = '0;
        {WR_DATA, CFG_DATA, PERIPH_EVENT, CH_NULL, QK_NULL} = '0;
        {PARAMETER_SET_RAM_WR_SET, PARAMETER_SET_RAM_WR_WORD, HIST_QUEUE, HIST_ENTRY} = '0;
        repeat (3) @(posedge SYS_CLK);
        RESET <= 1'b0;
        for (int i = 0; i < 10; i++)
            rd(dce_rsel_e'(i), 32'h0, "reset value");
        $display("test reset done");
        wr(W_EN_SET, 32'ha5);
        wr(W_EN_SET, 32'h0);
        rd(R_EN, 32'ha5, "enable set");
        wr(W_EN_CLR, 32'h05);
        rd(R_EN, 32'ha0, "enable clear");
        wr(W_EN_CLR, 32'ha0);
        $display("test enables done");
        pev(32'h10);
        rd(R_EV, 32'h10, "latch");
        wr(W_EN_CLR, 32'h10);
        rd(R_EV, 32'h10, "latch kept");
        wr(W_EV_CLR, 32'h10);
        rd(R_EV, 32'h0, "latch cleared");
        $display("test latch done");
        cfg(C_RMASK, 5'd1, 32'hf0);
        wr(W_IE_SET, 32'hff, 1'b1, 2'h1);
        rd(R_IE, 32'hf0, "shadow write");
        wr(W_IE_SET, 32'h0f);
        rd(R_IE, 32'hf0, "shadow read", 1'b1, 2'h1);
        wr(W_IE_CLR, 32'hff);
        $display("test shadow done");
        cfg(C_RMASK, 5'd0, 32'h8);
        cfg(C_RMASK, 5'd2, 32'h8);
        early <= 1'b1;
        code <= 5'd3;
        wr(W_EV_SET, 32'h8);
        wait_tr();
        chk("channel", 32'd3, {27'h0, TR_CHANNEL});
        chk("set", 32'd3, {25'h0, TR_PARAMETER_SET_RAM});
        idle(8);
        rd(R_IP, 32'h8, "early pending");
        chk("no int", 32'h0, {31'h0, CC_INT});
        wr(W_IE_SET, 32'h8);
        idle(2);
        chk("int", 32'h1, {31'h0, CC_INT});
        chk("regions", 32'h5, {28'h0, REGION_INT});
        wr(W_IP_CLR, 32'hffff_ffff);
        idle(2);
        chk("int clear", 32'h0, {31'h0, CC_INT});
        $display("test completion done");
        early <= 1'b0;
        chain <= 1'b1;
        code <= 5'd7;
        stall <= 4'd3;
        wr(W_EV_SET, 32'h4);
        wait_tr();
        chk("first", 32'd2, {27'h0, TR_CHANNEL});
        wait_tr();
        chk("chained", 32'd7, {27'h0, TR_CHANNEL});
        idle(10);
        rd(R_IP, 32'h80, "chain pending");
        wr(W_IP_CLR, 32'hffff_ffff);
        $display("test chain done");
        chain <= 1'b0;
        code <= 5'd5;
        cfg(C_CH_Q, 5'd5, 32'h2);
        wr(W_EN_SET, 32'h20);
        pev(32'h20);
        wait_tr();
        chk("queue", 32'h2, {30'h0, TR_QUEUE});
        chk("event ch", 32'd5, {27'h0, TR_CHANNEL});
        idle(10);
        rd(R_EV, 32'h0, "serviced");
        found = 1'b0;
        for (int e = 0; e < 4; e++)
        begin
            @(posedge SYS_CLK);
            HIST_QUEUE <= 2'h2;
            HIST_ENTRY <= 2'(e);
            idle(2);
            found = found | (HIST_DATA === 6'h05);
        end
        chk("history", 32'h1, {31'h0, found});
        $display("test queue done");
        cfg(C_QMAP, 5'd1, 32'h194);
        cfg(C_QK_Q, 5'd1, 32'h3);
        wr(W_QE_SET, 32'h2);
        rd(R_QE, 32'h2, "quick enable");
        pwr(7'd20, 3'd2);
        idle(4);
        chk("other word", 32'h0, {31'h0, TR_VALID});
        pwr(7'd20, 3'd3);
        wait_tr();
        chk("quick", 32'h1, {31'h0, TR_QUICK});
        chk("quick set", 32'd20, {25'h0, TR_PARAMETER_SET_RAM});
        chk("quick queue", 32'h3, {30'h0, TR_QUEUE});
        idle(10);
        $display("test quick done");
        @(posedge SYS_CLK);
        CH_NULL <= 32'h40;
        wr(W_EV_SET, 32'h40);
        idle(6);
        chk("null offer", 32'h0, {31'h0, TR_VALID});
        chk("idle", 32'h0, {31'h0, CC_ACTIVE});
        rd(R_MS, 32'h40, "missed");
        rd(R_SE, 32'h40, "secondary");
        $display("test null done");
        print_verdict();
    end
endmodule : dce_channel_ctl_tb
`default_nettype wire
